/* logic/dtc_pkg.sv */
`default_nettype none
package dtc_pkg;
    // bus shape
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_T3_CTL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_T3_PER = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_T3_PW = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_T4_CTL = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_T4_PER = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_T4_PW = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_CONFIG = 8'h1C;
    // control register fields
    localparam int CTL_PRESET_BIT = 7;
    localparam int CTL_CK_HI = 6;
    localparam int CTL_CK_LO = 4;
    localparam int CTL_RUN_BIT = 3;
    localparam int CTL_MODE_HI = 2;
    localparam int CTL_MODE_LO = 0;
    // config register fields
    localparam int CFG_LOWOPT_BIT = 0;
    localparam int CFG_SLOW_BIT = 1;
    // reset values
    localparam logic [7:0] REG8_RST = 8'h00;
    localparam logic [1:0] CFG_RST = 2'h0;
    // operating modes
    typedef enum logic [2:0] {
        MODE_TIMER = 3'b000,
        MODE_PDO = 3'b001,
        MODE_PWM = 3'b010,
        MODE_CASCADE = 3'b011,
        MODE_T16 = 3'b100,
        MODE_WARMUP = 3'b101,
        MODE_PWM16 = 3'b110,
        MODE_RSVD = 3'b111
    } dtc_mode_t;
    // source clock selects
    localparam logic [2:0] SEL_SLOWEST = 3'b000;
    localparam logic [2:0] SEL_FC_D7 = 3'b001;
    localparam logic [2:0] SEL_FC_D5 = 3'b010;
    localparam logic [2:0] SEL_FC_D3 = 3'b011;
    localparam logic [2:0] SEL_FS = 3'b100;
    localparam logic [2:0] SEL_FC_D1 = 3'b101;
    localparam logic [2:0] SEL_FC = 3'b110;
    localparam logic [2:0] SEL_PIN = 3'b111;
    // divider exponents
    localparam int DIV_W = 11;
    localparam int EXP_SLOWEST = 11;
    localparam int EXP_D7 = 7;
    localparam int EXP_D5 = 5;
    localparam int EXP_D3 = 3;
    localparam int EXP_D1 = 1;
    localparam logic [2:0] FS_DIV_LAST = 3'h7;
    // responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [7:0] CNT_TOP = 8'hFF;
    localparam logic [15:0] CNT16_TOP = 16'hFFFF;
endpackage : dtc_pkg
`default_nettype wire

/* logic/dtc_clock_select.sv */
`timescale 1ns/1ps
`default_nettype none
module dtc_clock_select (
    input wire logic clk, // system clock, high_freq_clock
    input wire logic sys_rst, // async reset, active high
    input wire logic [dtc_pkg::DIV_W-1:0] divCount, // shared prescaler
    input wire logic lowClkPin, // low_freq_clock pin
    input wire logic extPin, // external count pin
    input wire logic [2:0] sel, // clock select field
    input wire logic lowOpt, // divider_low_clock_option
    input wire logic slowMode, // slow or sleep operation
    input wire logic fcAllowed, // warm-up use of fc
    output logic tick // one-cycle count enable
);
    import dtc_pkg::*;

    logic [2:0] lowSync_reg, lowSync_next;
    logic [2:0] extSync_reg, extSync_next;
    logic [2:0] fsDiv_reg, fsDiv_next;
    logic fsTick, extTick, fs8Tick;

    // true when the low n prescaler bits are all ones
    function automatic logic fcTick(input logic [DIV_W-1:0] cnt,
                                    input int n);
        logic [DIV_W-1:0] mask;
        mask = DIV_W'((32'h1 << n) - 32'h1);
        return (cnt & mask) == mask;
    endfunction : fcTick

    // synchronisers, rising edge detect, low clock divide by eight
    always_comb begin
        lowSync_next = {lowSync_reg[1:0], lowClkPin};
        extSync_next = {extSync_reg[1:0], extPin};
        fsTick = lowSync_reg[1] & ~lowSync_reg[2];
        extTick = extSync_reg[1] & ~extSync_reg[2];
        fsDiv_next = fsTick ? fsDiv_reg + 3'h1 : fsDiv_reg;
        fs8Tick = fsTick && (fsDiv_reg == FS_DIV_LAST);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lowSync_reg <= 3'h0;
            extSync_reg <= 3'h0;
            fsDiv_reg <= 3'h0;
        end else begin
            lowSync_reg <= lowSync_next;
            extSync_reg <= extSync_next;
            fsDiv_reg <= fsDiv_next;
        end
    end

    // source clock mux
    always_comb begin
        unique case (sel)
            SEL_SLOWEST: tick = (lowOpt || slowMode) ? fs8Tick
                : fcTick(divCount, EXP_SLOWEST);
            SEL_FC_D7: tick = !slowMode && fcTick(divCount, EXP_D7);
            SEL_FC_D5: tick = !slowMode && fcTick(divCount, EXP_D5);
            SEL_FC_D3: tick = !slowMode && fcTick(divCount, EXP_D3);
            SEL_FS: tick = fsTick;
            SEL_FC_D1: tick = !slowMode && fcTick(divCount, EXP_D1);
            SEL_FC: tick = !slowMode || fcAllowed;
            SEL_PIN: tick = extTick;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    property p_fc8;
        @(posedge clk) disable iff (sys_rst)
        (sel == SEL_FC_D3 && !slowMode && tick) |=>
            (!tick || sel != SEL_FC_D3)[*7];
    endproperty
    a_fc8: assert property (p_fc8)
        else $error("divide-by-8 source ticked early");

    property p_fc_slow;
        @(posedge clk) disable iff (sys_rst)
        (sel == SEL_FC && slowMode && !fcAllowed) |-> !tick;
    endproperty
    a_fc_slow: assert property (p_fc_slow)
        else $error("undivided clock used in slow mode");
endmodule : dtc_clock_select
`default_nettype wire

/* logic/dtc_timer_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - unit three has control, 8-bit period and 8-bit pulse-width registers.
// - unit four mirrors unit three with its own three registers.
// - clock select picks prescaled high, low, or pin clock per code.
// - run bit 0 halts and clears the counter; 1 runs it.
// - mode 001 divider output, 010 PWM, 011 sixteen-bit chained.
// - the starting write may load new mode, clock and preset.
// - chained use needs unit three mode 011; unit four picks mode.
// - chained clock from unit three; run and preset from unit four.
// - undivided high clock in slow mode only for warm-up.
module dtc_timer_top (
    input wire logic clk, // 100 MHz system clock
    input wire logic sys_rst, // async reset, active high
    input wire logic [dtc_pkg::ADDR_W-1:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [dtc_pkg::DATA_W-1:0] wdata, // write data
    input wire logic [3:0] wstrb, // byte enables
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [dtc_pkg::ADDR_W-1:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [dtc_pkg::DATA_W-1:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    input wire logic lowClkPin, // low frequency clock pin
    input wire logic timer3Pin, // unit three external count pin
    input wire logic timer4Pin, // unit four external count pin
    output logic timer3Out, // unit three output flip-flop
    output logic timer4Out // unit four output flip-flop
);
    import dtc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // bus slave state
    logic awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
    logic [ADDR_W-1:0] awAddr_reg, awAddr_next;
    logic [7:0] wByte_reg, wByte_next;
    logic wEn_reg, wEn_next;
    logic awready_reg, awready_next, wready_reg, wready_next;
    logic bvalid_reg, bvalid_next, arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic doWrite;
    // register file
    logic [7:0] ctl3_reg, ctl3_next, per3_reg, per3_next, pw3_reg, pw3_next;
    logic [7:0] ctl4_reg, ctl4_next, per4_reg, per4_next, pw4_reg, pw4_next;
    logic [1:0] cfg_reg, cfg_next;
    // timer state
    logic [DIV_W-1:0] div_reg, div_next;
    logic [7:0] cnt3_reg, cnt3_next, cnt4_reg, cnt4_next;
    logic [7:0] pwb3_reg, pwb3_next, pwb4_reg, pwb4_next;
    logic ff3_reg, ff3_next, ff4_reg, ff4_next;
    logic run3Prev_reg, run3Prev_next, run4Prev_reg, run4Prev_next;
    logic tick3, tick4, chained, run3, run4, start3, start4, warm;
    logic [2:0] mode3, mode4;
    logic [15:0] c16, c16Inc, pw16;
    logic [8:0] step3, step4;

    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        return a == OFF_T3_CTL || a == OFF_T3_PER || a == OFF_T3_PW ||
               a == OFF_T4_CTL || a == OFF_T4_PER || a == OFF_T4_PW ||
               a == OFF_STATUS || a == OFF_CONFIG;
    endfunction : isMapped

    // one source tick of an 8-bit unit: returns {flip-flop, counter}
    function automatic logic [8:0] unitStep(input logic [2:0] mode,
        input logic [7:0] cnt, input logic [7:0] per,
        input logic [7:0] pwb, input logic ff);
        logic [7:0] nxt;
        logic f;
        nxt = cnt + 8'h01;
        f = ff;
        unique case (mode)
            MODE_PWM: begin
                if (nxt == pwb) f = ~f;
                if (cnt == CNT_TOP) f = ~f;
            end
            MODE_PDO: if (nxt == per) begin
                nxt = REG8_RST;
                f = ~f;
            end
            default: if (nxt == per) nxt = REG8_RST;
        endcase
        return {f, nxt};
    endfunction : unitStep

    ////////////////////////////////////////////////////////////////////////
    // write and read channels
    always_comb begin
        awHeld_next = awHeld_reg;
        wHeld_next = wHeld_reg;
        awAddr_next = awAddr_reg;
        wByte_next = wByte_reg;
        wEn_next = wEn_reg;
        bvalid_next = bvalid_reg && !bready;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg && !rready;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        doWrite = awHeld_reg && wHeld_reg && !bvalid_reg;
        if (awvalid && awready_reg) begin
            awHeld_next = 1'b1;
            awAddr_next = awaddr;
        end
        if (wvalid && wready_reg) begin
            wHeld_next = 1'b1;
            wByte_next = wdata[7:0];
            wEn_next = wstrb[0];
        end
        if (doWrite) begin
            awHeld_next = 1'b0;
            wHeld_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = isMapped(awAddr_reg) ? RESP_OKAY : RESP_SLVERR;
        end
        if (arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next = isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (araddr)
                OFF_T3_CTL: rdata_next = DATA_W'(ctl3_reg);
                OFF_T3_PER: rdata_next = DATA_W'(per3_reg);
                OFF_T3_PW: rdata_next = DATA_W'(pw3_reg);
                OFF_T4_CTL: rdata_next = DATA_W'(ctl4_reg);
                OFF_T4_PER: rdata_next = DATA_W'(per4_reg);
                OFF_T4_PW: rdata_next = DATA_W'(pw4_reg);
                OFF_STATUS: rdata_next =
                    DATA_W'({ff4_reg, ff3_reg, cnt4_reg, cnt3_reg});
                OFF_CONFIG: rdata_next = DATA_W'(cfg_reg);
                default: rdata_next = '0;
            endcase
        end
        awready_next = !awHeld_next && !bvalid_next;
        wready_next = !wHeld_next && !bvalid_next;
        arready_next = !rvalid_next;
    end

    // register file writes, whole fields at once so a start can reload
    always_comb begin
        ctl3_next = ctl3_reg;
        per3_next = per3_reg;
        pw3_next = pw3_reg;
        ctl4_next = ctl4_reg;
        per4_next = per4_reg;
        pw4_next = pw4_reg;
        cfg_next = cfg_reg;
        if (doWrite && wEn_reg) begin
            unique case (awAddr_reg)
                OFF_T3_CTL: ctl3_next = wByte_reg;
                OFF_T3_PER: per3_next = wByte_reg;
                OFF_T3_PW: pw3_next = wByte_reg;
                OFF_T4_CTL: ctl4_next = wByte_reg;
                OFF_T4_PER: per4_next = wByte_reg;
                OFF_T4_PW: pw4_next = wByte_reg;
                OFF_CONFIG: cfg_next = wByte_reg[1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control decode, chained unit takes run and preset from unit four
    assign mode3 = ctl3_reg[CTL_MODE_HI:CTL_MODE_LO];
    assign mode4 = ctl4_reg[CTL_MODE_HI:CTL_MODE_LO];
    assign chained = mode3 == MODE_CASCADE;
    assign run4 = ctl4_reg[CTL_RUN_BIT];
    assign run3 = chained ? run4 : ctl3_reg[CTL_RUN_BIT];
    assign start3 = run3 && !run3Prev_reg;
    assign start4 = run4 && !run4Prev_reg;
    assign warm = chained && mode4 == MODE_WARMUP;
    assign c16 = {cnt4_reg, cnt3_reg};
    assign c16Inc = c16 + 16'h0001;
    assign pw16 = {pwb4_reg, pwb3_reg};
    assign step3 = unitStep(mode3, cnt3_reg, per3_reg, pwb3_reg, ff3_reg);
    assign step4 = unitStep(mode4, cnt4_reg, per4_reg, pwb4_reg, ff4_reg);

    dtc_clock_select u_clk3 (
        .clk(clk),
        .sys_rst(sys_rst),
        .divCount(div_reg),
        .lowClkPin(lowClkPin),
        .extPin(timer3Pin),
        .sel(ctl3_reg[CTL_CK_HI:CTL_CK_LO]),
        .lowOpt(cfg_reg[CFG_LOWOPT_BIT]),
        .slowMode(cfg_reg[CFG_SLOW_BIT]),
        .fcAllowed(warm),
        .tick(tick3)
    );

    dtc_clock_select u_clk4 (
        .clk(clk),
        .sys_rst(sys_rst),
        .divCount(div_reg),
        .lowClkPin(lowClkPin),
        .extPin(timer4Pin),
        .sel(ctl4_reg[CTL_CK_HI:CTL_CK_LO]),
        .lowOpt(cfg_reg[CFG_LOWOPT_BIT]),
        .slowMode(cfg_reg[CFG_SLOW_BIT]),
        .fcAllowed(1'b0),
        .tick(tick4)
    );

    // counters, output flip-flops, pulse width buffers
    always_comb begin
        div_next = div_reg + DIV_W'(1);
        cnt3_next = cnt3_reg;
        cnt4_next = cnt4_reg;
        ff3_next = ff3_reg;
        ff4_next = ff4_reg;
        pwb3_next = pwb3_reg;
        pwb4_next = pwb4_reg;
        run3Prev_next = run3;
        run4Prev_next = run4;
        if (!run3 || (chained && cnt3_reg == CNT_TOP && cnt4_reg == CNT_TOP)
            || (!chained && cnt3_reg == CNT_TOP)) pwb3_next = pw3_reg;
        if (!run4 || cnt4_reg == CNT_TOP) pwb4_next = pw4_reg;
        if (chained) begin
            if (!run4) begin
                {cnt4_next, cnt3_next} = 16'h0000;
            end else if (start4) begin
                {cnt4_next, cnt3_next} = 16'h0000;
                ff4_next = ctl4_reg[CTL_PRESET_BIT];
            end else if (tick3) begin
                {cnt4_next, cnt3_next} = c16Inc;
                if (mode4 == MODE_PWM16) begin
                    if (c16Inc == pw16) ff4_next = ~ff4_reg;
                    if (c16 == CNT16_TOP) ff4_next = ~ff4_reg;
                end else if (c16Inc == {per4_reg, per3_reg}) begin
                    {cnt4_next, cnt3_next} = 16'h0000;
                end
            end
        end else begin
            if (!run3) begin
                cnt3_next = REG8_RST;
            end else if (start3) begin
                cnt3_next = REG8_RST;
                ff3_next = ctl3_reg[CTL_PRESET_BIT];
            end else if (tick3) begin
                {ff3_next, cnt3_next} = step3;
            end
            if (!run4) begin
                cnt4_next = REG8_RST;
            end else if (start4) begin
                cnt4_next = REG8_RST;
                ff4_next = ctl4_reg[CTL_PRESET_BIT];
            end else if (tick4) begin
                {ff4_next, cnt4_next} = step4;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= '0;
            wByte_reg <= REG8_RST;
            wEn_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= '0;
            ctl3_reg <= REG8_RST;
            per3_reg <= REG8_RST;
            pw3_reg <= REG8_RST;
            ctl4_reg <= REG8_RST;
            per4_reg <= REG8_RST;
            pw4_reg <= REG8_RST;
            cfg_reg <= CFG_RST;
            div_reg <= '0;
            cnt3_reg <= REG8_RST;
            cnt4_reg <= REG8_RST;
            pwb3_reg <= REG8_RST;
            pwb4_reg <= REG8_RST;
            ff3_reg <= 1'b0;
            ff4_reg <= 1'b0;
            run3Prev_reg <= 1'b0;
            run4Prev_reg <= 1'b0;
        end else begin
            awHeld_reg <= awHeld_next;
            wHeld_reg <= wHeld_next;
            awAddr_reg <= awAddr_next;
            wByte_reg <= wByte_next;
            wEn_reg <= wEn_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            ctl3_reg <= ctl3_next;
            per3_reg <= per3_next;
            pw3_reg <= pw3_next;
            ctl4_reg <= ctl4_next;
            per4_reg <= per4_next;
            pw4_reg <= pw4_next;
            cfg_reg <= cfg_next;
            div_reg <= div_next;
            cnt3_reg <= cnt3_next;
            cnt4_reg <= cnt4_next;
            pwb3_reg <= pwb3_next;
            pwb4_reg <= pwb4_next;
            ff3_reg <= ff3_next;
            ff4_reg <= ff4_next;
            run3Prev_reg <= run3Prev_next;
            run4Prev_reg <= run4Prev_next;
        end
    end

    // outputs straight from flip-flops
    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rresp = rresp_reg;
    assign rdata = rdata_reg;
    assign timer3Out = ff3_reg;
    assign timer4Out = ff4_reg;

    ////////////////////////////////////////////////////////////////////////
    property p_per3;
        @(posedge clk) disable iff (sys_rst)
        (doWrite && wEn_reg && awAddr_reg == OFF_T3_PER)
            |=> per3_reg == $past(wByte_reg);
    endproperty
    a_per3: assert property (p_per3)
        else $error("period write lost");

    property p_stop;
        @(posedge clk) disable iff (sys_rst)
        !run3 |=> cnt3_reg == REG8_RST;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stopped counter not cleared");

    property p_preset;
        @(posedge clk) disable iff (sys_rst)
        (!chained && start3) |=> ff3_reg == $past(ctl3_reg[CTL_PRESET_BIT]);
    endproperty
    a_preset: assert property (p_preset)
        else $error("preset not loaded at start");

    property p_pdo;
        @(posedge clk) disable iff (sys_rst)
        (!chained && run3 && !start3 && tick3 && mode3 == MODE_PDO &&
         step3[7:0] == REG8_RST) |=> ff3_reg != $past(ff3_reg);
    endproperty
    a_pdo: assert property (p_pdo)
        else $error("divider output did not toggle");

    property p_timer;
        @(posedge clk) disable iff (sys_rst)
        (!chained && run3 && !start3 && tick3 && mode3 == MODE_TIMER &&
         cnt3_reg + 8'h01 == per3_reg) |=> cnt3_reg == REG8_RST;
    endproperty
    a_timer: assert property (p_timer)
        else $error("timer did not clear at period");

    property p_start_load;
        @(posedge clk) disable iff (sys_rst)
        (doWrite && wEn_reg && awAddr_reg == OFF_T3_CTL &&
         !ctl3_reg[CTL_RUN_BIT] && wByte_reg[CTL_RUN_BIT])
            |=> mode3 == $past(wByte_reg[CTL_MODE_HI:CTL_MODE_LO]);
    endproperty
    a_start_load: assert property (p_start_load)
        else $error("start write dropped mode");

    property p_carry;
        @(posedge clk) disable iff (sys_rst)
        (chained && run4 && !start4 && tick3 && mode4 == MODE_T16 &&
         cnt3_reg == CNT_TOP && c16Inc != {per4_reg, per3_reg})
            |=> cnt4_reg == $past(cnt4_reg) + 8'h01;
    endproperty
    a_carry: assert property (p_carry)
        else $error("chained carry missing");

    property p_chain_run;
        @(posedge clk) disable iff (sys_rst)
        (chained && !run4) |=> (c16 == 16'h0000);
    endproperty
    a_chain_run: assert property (p_chain_run)
        else $error("chained counter ran while unit four stopped");
endmodule : dtc_timer_top
`default_nettype wire

/* bench/dual_8bit_timer_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_8bit_timer_control_tb;
import dtc_pkg::*;
logic clk, sysRst, awvalid, wvalid, bready, arvalid, rready, pin3;
logic pin4, lowPin;
logic awready, wready, bvalid, arready, rvalid, out3, out4;
logic [7:0] awaddr, araddr;
logic [31:0] wdata, rdata, rd;
logic [3:0] wstrb;
logic [1:0] bresp, rresp, rs;
logic [31:0] mdl [8];
int errors, compares, cycles, i, seed, r0;
dtc_timer_top dut (.clk(clk), .sys_rst(sysRst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .lowClkPin(lowPin), .timer3Pin(pin3), .timer4Pin(pin4),
    .timer3Out(out3), .timer4Out(out4));
////////////////////////////////////////////////////////////////////////////
task automatic end_of_test;
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
endtask : end_of_test
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
        errors++;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
endtask : chk
// write one word, model the stored low byte
task automatic wchk(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a; awvalid <= 1; wdata <= d; wstrb <= 4'h1; wvalid <= 1;
    bready <= 1;
    forever begin
        @(posedge clk);
        if (awready) awvalid <= 0;
        if (wready) wvalid <= 0;
        if (bvalid) begin rs = bresp; bready <= 0; break; end
    end
    chk({30'h0, rs}, (a > OFF_CONFIG) ? RESP_SLVERR : RESP_OKAY);
    if (a <= OFF_CONFIG && a != OFF_STATUS)
        mdl[a[4:2]] = (a == OFF_CONFIG) ? {30'h0, d[1:0]} : {24'h0, d[7:0]};
endtask : wchk
task automatic rdw(input logic [7:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    forever begin
        @(posedge clk);
        if (arready) arvalid <= 0;
        if (rvalid) begin rd = rdata; rs = rresp; rready <= 0; break; end
    end
endtask : rdw
task automatic pulse(input int n);
    repeat (n) begin
        {pin3, pin4, lowPin} <= 3'b111; repeat (4) @(posedge clk);
        {pin3, pin4, lowPin} <= 3'b000; repeat (4) @(posedge clk);
    end
endtask : pulse
////////////////////////////////////////////////////////////////////////////
// clock and hang guard
initial begin clk = 0; forever #5 clk = ~clk; end
always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin errors++; end_of_test(); end
end
// main sequence
initial begin
    {awvalid, wvalid, bready, arvalid, rready, pin3, pin4, lowPin} = '0;
    awaddr = '0; araddr = '0; wdata = '0; wstrb = '0; sysRst = 1;
    seed = 32'h6a93_da20;
    for (i = 0; i < 8; i++) mdl[i] = '0;
    repeat (12) @(posedge clk);
    sysRst <= 0;
    // reset values and random period and width storage
    for (i = 0; i < 8; i++) begin rdw(8'(i * 4)); chk(rd, 0); end
    for (i = 1; i < 6; i++) if (i != 3) begin
        wchk(8'(i * 4), $random(seed));
        rdw(8'(i * 4)); chk(rd, mdl[i]);
    end
    wchk(8'h20, 32'h0000_00ff);
    rdw(8'h20); chk({30'h0, rs}, RESP_SLVERR);
    // divider output from pin, preset set at start
    wchk(OFF_T3_PER, 32'h0000_0003);
    wchk(OFF_T3_CTL, 32'h0000_00f9);
    rdw(OFF_STATUS); chk(rd & 32'h1_ffff, 32'h1_0000);
    chk({31'h0, out3}, 32'h1);
    pulse(3);
    rdw(OFF_STATUS); chk(rd & 32'h1_ffff, 32'h0_0000);
    chk({31'h0, out3}, 32'h0);
    pulse(2);
    rdw(OFF_STATUS); chk(rd & 32'hffff, 32'h0002);
    wchk(OFF_T3_CTL, 32'h0000_00f1);
    rdw(OFF_STATUS); chk(rd & 32'hffff, 32'h0000);
    // undivided high clock blocked in slow mode
    wchk(OFF_CONFIG, 32'h0000_0002);
    wchk(OFF_T3_CTL, 32'h0000_0068);
    repeat (40) @(posedge clk);
    rdw(OFF_STATUS); chk(rd & 32'hffff, 32'h0000);
    wchk(OFF_T3_CTL, 32'h0000_0060);
    wchk(OFF_CONFIG, 32'h0000_0000);
    // divide-by-eight source, modulo-seven period model, 80 edges apart
    wchk(OFF_T3_PER, 32'h0000_0007);
    wchk(OFF_T3_CTL, 32'h0000_0038);
    rdw(OFF_STATUS); r0 = rd[7:0];
    repeat (77) @(posedge clk);
    rdw(OFF_STATUS); chk(rd & 32'hff, (r0 + 10) % 7);
    wchk(OFF_T3_CTL, 32'h0000_0030);
    // unit four divider output on the low clock, preset set at start
    wchk(OFF_T4_PER, 32'h0000_0002);
    wchk(OFF_T4_CTL, 32'h0000_00c9);
    rdw(OFF_STATUS); chk(rd & 32'h2_ff00, 32'h2_0000);
    chk({31'h0, out4}, 32'h1);
    pulse(2);
    rdw(OFF_STATUS); chk(rd & 32'h2_ff00, 32'h0);
    chk({31'h0, out4}, 32'h0);
    wchk(OFF_T4_CTL, 32'h0000_00c1);
    // chained sixteen-bit count, clock from unit three, run from unit four
    wchk(OFF_T3_PER, 32'h0000_00ff);
    wchk(OFF_T4_PER, 32'h0000_00ff);
    wchk(OFF_T3_CTL, 32'h0000_0073);
    wchk(OFF_T4_CTL, 32'h0000_000c);
    pulse(260);
    rdw(OFF_STATUS); chk(rd & 32'hffff, 32'd260);
    wchk(OFF_T4_CTL, 32'h0000_0004);
    rdw(OFF_STATUS); chk(rd & 32'hffff, 32'h0000);
    // warm-up count on the undivided clock still runs in slow mode
    wchk(OFF_CONFIG, 32'h0000_0002);
    wchk(OFF_T3_CTL, 32'h0000_0063);
    wchk(OFF_T4_CTL, 32'h0000_000d);
    rdw(OFF_STATUS); r0 = rd[15:0];
    repeat (77) @(posedge clk);
    rdw(OFF_STATUS); chk(rd & 32'hffff, r0 + 80);
    wchk(OFF_T4_CTL, 32'h0000_0005);
    rdw(OFF_STATUS); chk(rd & 32'hffff, 32'h0000);
    end_of_test();
end
endmodule : dual_8bit_timer_control_tb
`default_nettype wire
